// ==== inc/pomc_defs.vh ====
// Constants for the PHY operating mode configuration block.
`ifndef POMC_DEFS_VH
`define POMC_DEFS_VH

`define POMC_AW        12
`define POMC_A_GIF     12'h000
`define POMC_A_CMD     12'h004
`define POMC_A_BCAST   12'h008
`define POMC_A_PSEL    12'h00C
`define POMC_A_CTRL    12'h010
`define POMC_A_MODE    12'h014
`define POMC_A_MACX    12'h018
`define POMC_A_EXTST   12'h01C
`define POMC_A_CSTAT   12'h020

`define POMC_GIF_HI    15
`define POMC_GIF_LO    14
`define POMC_GIF_SGMII 2'h0
`define POMC_GIF_QSG   2'h1

`define POMC_CMD_MAC   16'h80F0
`define POMC_CMD_QMAC  16'h80E0
`define POMC_CMD_X     8'hC1
`define POMC_CMD_FX    8'hD1
`define POMC_CMD_GO    15
`define POMC_CMD_MHI   11
`define POMC_CMD_MLO   8

`define POMC_CTL_RST   15
`define POMC_CTL_ANEG  12
`define POMC_MD_MACX   12
`define POMC_MD_PREF   11
`define POMC_MD_AMS    10
`define POMC_MD_MHI    10
`define POMC_MD_MLO    8
`define POMC_MED_CU    3'h1
`define POMC_MED_X     3'h2
`define POMC_MED_FX    3'h3
`define POMC_MX_CL37   7
`define POMC_ST_HI     7
`define POMC_ST_LO     6

`define POMC_SEL_NONE  2'h0
`define POMC_SEL_CU    2'h1
`define POMC_SEL_SER   2'h2

`define POMC_CTL_RSTV  16'h1000
`define POMC_MODE_RSTV 16'h0000
`define POMC_MACX_RSTV 16'h0000
`define POMC_GIF_RSTV  16'h0000

`endif

// ==== rtl/pomc_port.v ====
// One port's control, pending and active mode, and media selection.
`timescale 1ns/1ps
`include "pomc_defs.vh"

module pomc_port #(
  parameter [1:0] PORT_ID = 2'h0
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Register writes
  input  wire        wr_ctrl,
  input  wire        wr_mode,
  input  wire        wr_macx,
  input  wire [15:0] wdata,
  // Device context
  input  wire        qsgmii,
  input  wire        sig_det,
  input  wire        cu_link,
  // State
  output reg  [15:0] ctrl_r,
  output reg  [15:0] act_r,
  output reg  [15:0] macx_r,
  output reg  [1:0]  media_sel_r,
  output reg  [1:0]  mac_lane_r,
  output reg         aneg_on_r,
  output reg         only_1000_r
);

  reg  [15:0] pend_r;
  reg  [1:0]  media_sel_nxt;
  wire [2:0]  med;
  wire        fx_alone;

  assign med      = act_r[`POMC_MD_MHI:`POMC_MD_MLO];
  assign fx_alone = (med == `POMC_MED_FX) && !act_r[`POMC_MD_AMS];

  //////////////////////////////////////////////////////////////////////////////

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `POMC_CTL_RSTV;
      pend_r <= `POMC_MODE_RSTV;
      act_r  <= `POMC_MODE_RSTV;
      macx_r <= `POMC_MACX_RSTV;
    end else begin
      if (wr_mode) begin
        pend_r <= wdata;
      end
      if (wr_ctrl) begin
        // The reset bit clears itself so a read never sees it stuck.
        ctrl_r <= wdata & ~(16'h0001 << `POMC_CTL_RST);
        if (wdata[`POMC_CTL_RST]) begin
          act_r <= pend_r;
        end
      end
      if (wr_macx) begin
        macx_r <= wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always @* begin
    media_sel_nxt = `POMC_SEL_NONE;
    if (act_r[`POMC_MD_AMS]) begin
      if (act_r[`POMC_MD_PREF]) begin
        media_sel_nxt = sig_det ? `POMC_SEL_SER : (cu_link ? `POMC_SEL_CU : `POMC_SEL_NONE);
      end else begin
        media_sel_nxt = cu_link ? `POMC_SEL_CU : (sig_det ? `POMC_SEL_SER : `POMC_SEL_NONE);
      end
    end else begin
      media_sel_nxt = (med != 3'h0) ? `POMC_SEL_SER : `POMC_SEL_CU;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      media_sel_r <= `POMC_SEL_NONE;
      mac_lane_r  <= 2'h0;
      aneg_on_r   <= 1'b0;
      only_1000_r <= 1'b0;
    end else begin
      media_sel_r <= media_sel_nxt;
      mac_lane_r  <= qsgmii ? 2'h0 : PORT_ID;
      aneg_on_r   <= ctrl_r[`POMC_CTL_ANEG] && !fx_alone;
      only_1000_r <= act_r[`POMC_MD_MACX];
    end
  end

endmodule

// ==== rtl/pomc_top.v ====
// APB register bank selecting MAC, media and sensing modes of a quad PHY.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pomc_defs.vh"

module pomc_top #(
  parameter NPORT = 4
) (
  // Clock and reset
  input  wire                clk_sys,
  input  wire                rstn,
  // APB slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [31:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  // Media detection per port
  input  wire [NPORT-1:0]    serdes_sig_det,
  input  wire [NPORT-1:0]    cu_link_up,
  // Global configuration
  output reg  [1:0]          mac_if_mode,
  output reg                 mac_serdes_sgmii_x,
  output reg                 mac_serdes_qsgmii,
  output reg  [NPORT-1:0]    media_x_mask,
  output reg  [NPORT-1:0]    media_fx_mask,
  // Per-port active configuration
  output wire [NPORT-1:0]    port_mac_1000x,
  output wire [3*NPORT-1:0]  port_media_mode,
  output wire [NPORT-1:0]    port_auto_media_sensing,
  output wire [NPORT-1:0]    port_aneg_en,
  output wire [NPORT-1:0]    port_cl37_en,
  output wire [NPORT-1:0]    port_speed_1000_only,
  output wire [2*NPORT-1:0]  port_media_sel,
  output wire [2*NPORT-1:0]  port_mac_lane
);

  //////////////////////////////////////////////////////////////////////////////
  // Command decode helper.

  // Returns the port mask of a media setup command whose low byte is tail.
  function [3:0] pomc_cmd_mask;
    input [15:0] c;
    input [7:0]  tail;
    begin
      pomc_cmd_mask = 4'h0;
      if (c[`POMC_CMD_GO] && (c[7:0] == tail)) begin
        pomc_cmd_mask = c[`POMC_CMD_MHI:`POMC_CMD_MLO];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire [`POMC_AW-1:0] addr;
  wire                setup;
  wire                access;
  wire                wr;
  wire                mapped;
  wire                hi_zero;

  assign addr    = paddr[`POMC_AW-1:0];
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign wr      = access && pwrite && !pslverr;
  assign hi_zero = (paddr[31:`POMC_AW] == 20'h0_0000);
  assign mapped  = hi_zero && (
                     (addr == `POMC_A_GIF)   || (addr == `POMC_A_CMD)   ||
                     (addr == `POMC_A_BCAST) || (addr == `POMC_A_PSEL)  ||
                     (addr == `POMC_A_CTRL)  || (addr == `POMC_A_MODE)  ||
                     (addr == `POMC_A_MACX)  || (addr == `POMC_A_EXTST) ||
                     (addr == `POMC_A_CSTAT));

  //////////////////////////////////////////////////////////////////////////////
  // Global registers.

  reg  [15:0] gif_r;
  reg  [15:0] cmd_r;
  reg         bcast_r;
  reg  [1:0]  port_sel_r;
  wire [15:0] wd16;
  wire [3:0]  x_mask_nxt;
  wire [3:0]  fx_mask_nxt;

  assign wd16        = pwdata[15:0];
  assign x_mask_nxt  = pomc_cmd_mask(wd16, `POMC_CMD_X);
  assign fx_mask_nxt = pomc_cmd_mask(wd16, `POMC_CMD_FX);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gif_r              <= `POMC_GIF_RSTV;
      cmd_r              <= 16'h0000;
      bcast_r            <= 1'b0;
      port_sel_r         <= 2'h0;
      mac_if_mode        <= `POMC_GIF_SGMII;
      mac_serdes_sgmii_x <= 1'b0;
      mac_serdes_qsgmii  <= 1'b0;
      media_x_mask       <= {NPORT{1'b0}};
      media_fx_mask      <= {NPORT{1'b0}};
    end else begin
      if (wr && (addr == `POMC_A_GIF)) begin
        gif_r       <= wd16;
        mac_if_mode <= wd16[`POMC_GIF_HI:`POMC_GIF_LO];
      end
      if (wr && (addr == `POMC_A_CMD)) begin
        // The command runs in its write cycle, so the go bit reads back clear.
        cmd_r <= wd16 & ~(16'h0001 << `POMC_CMD_GO);
        if (wd16 == `POMC_CMD_MAC) begin
          mac_serdes_sgmii_x <= 1'b1;
          mac_serdes_qsgmii  <= 1'b0;
        end
        if (wd16 == `POMC_CMD_QMAC) begin
          mac_serdes_sgmii_x <= 1'b0;
          mac_serdes_qsgmii  <= 1'b1;
        end
        if (x_mask_nxt != 4'h0) begin
          media_x_mask  <= x_mask_nxt[NPORT-1:0];
          media_fx_mask <= media_fx_mask & ~x_mask_nxt[NPORT-1:0];
        end
        if (fx_mask_nxt != 4'h0) begin
          media_fx_mask <= fx_mask_nxt[NPORT-1:0];
          media_x_mask  <= media_x_mask & ~fx_mask_nxt[NPORT-1:0];
        end
      end
      if (wr && (addr == `POMC_A_BCAST)) begin
        bcast_r <= pwdata[0];
      end
      if (wr && (addr == `POMC_A_PSEL)) begin
        port_sel_r <= pwdata[1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Ports.

  wire [16*NPORT-1:0] ctrl_v;
  wire [16*NPORT-1:0] act_v;
  wire [16*NPORT-1:0] macx_v;
  wire [NPORT-1:0]    port_hit;
  wire                qsg;

  assign qsg = (mac_if_mode == `POMC_GIF_QSG);

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : gp
      localparam [31:0] GW  = g;
      localparam [1:0]  PID = GW[1:0];
      assign port_hit[g] = bcast_r || (port_sel_r == PID);

      pomc_port #(
        .PORT_ID (PID)
      ) u_port (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .wr_ctrl     (wr && port_hit[g] && (addr == `POMC_A_CTRL)),
        .wr_mode     (wr && port_hit[g] && (addr == `POMC_A_MODE)),
        .wr_macx     (wr && port_hit[g] && (addr == `POMC_A_MACX)),
        .wdata       (wd16),
        .qsgmii      (qsg),
        .sig_det     (serdes_sig_det[g]),
        .cu_link     (cu_link_up[g]),
        .ctrl_r      (ctrl_v[16*g+15:16*g]),
        .act_r       (act_v[16*g+15:16*g]),
        .macx_r      (macx_v[16*g+15:16*g]),
        .media_sel_r (port_media_sel[2*g+1:2*g]),
        .mac_lane_r  (port_mac_lane[2*g+1:2*g]),
        .aneg_on_r   (port_aneg_en[g]),
        .only_1000_r (port_speed_1000_only[g])
      );

      assign port_mac_1000x[g]          = act_v[16*g+`POMC_MD_MACX];
      assign port_media_mode[3*g+2:3*g] = act_v[16*g+`POMC_MD_MHI:16*g+`POMC_MD_MLO];
      assign port_auto_media_sensing[g] = act_v[16*g+`POMC_MD_AMS];
      assign port_cl37_en[g]            = macx_v[16*g+`POMC_MX_CL37];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read data.

  reg  [31:0] rd_nxt;
  reg  [15:0] sel_ctrl;
  reg  [15:0] sel_act;
  reg  [15:0] sel_macx;
  reg  [1:0]  sel_med;
  integer     i;

  always @* begin
    sel_ctrl = 16'h0000;
    sel_act  = 16'h0000;
    sel_macx = 16'h0000;
    sel_med  = 2'h0;
    for (i = 0; i < NPORT; i = i + 1) begin
      if (port_sel_r == i[1:0]) begin
        sel_ctrl = ctrl_v[16*i +: 16];
        sel_act  = act_v[16*i +: 16];
        sel_macx = macx_v[16*i +: 16];
        sel_med  = port_media_sel[2*i +: 2];
      end
    end
  end

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (addr)
      `POMC_A_GIF: begin
        rd_nxt[15:0] = gif_r;
      end
      `POMC_A_CMD: begin
        rd_nxt[15:0] = cmd_r;
      end
      `POMC_A_BCAST: begin
        rd_nxt[0] = bcast_r;
      end
      `POMC_A_PSEL: begin
        rd_nxt[1:0] = port_sel_r;
      end
      `POMC_A_CTRL: begin
        rd_nxt[15:0] = sel_ctrl;
      end
      `POMC_A_MODE: begin
        rd_nxt[15:0] = sel_act;
      end
      `POMC_A_MACX: begin
        rd_nxt[15:0] = sel_macx;
      end
      `POMC_A_EXTST: begin
        rd_nxt[`POMC_ST_HI:`POMC_ST_LO] = sel_med;
      end
      `POMC_A_CSTAT: begin
        rd_nxt[NPORT-1:0]       = media_x_mask;
        rd_nxt[NPORT+3:4]       = media_fx_mask;
        rd_nxt[8]               = mac_serdes_sgmii_x;
        rd_nxt[9]               = mac_serdes_qsgmii;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
    if (!hi_zero) begin
      rd_nxt = 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB answer.

  // Zero wait states: the answer is prepared in the setup cycle, so pready
  // and prdata are flops and the access phase always ends after one cycle.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      if (setup) begin
        pready  <= 1'b1;
        pslverr <= !mapped;
        prdata  <= (!pwrite && mapped) ? rd_nxt : 32'h0000_0000;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

endmodule

// ==== verif/pomc_media_model.sv ====
// Media presence model standing on the line side of the four ports.
`timescale 1ns/1ps

module pomc_media_model #(
  parameter NPORT = 4
) (
  // Clock
  input  wire logic             clk_sys,
  // Requested presence
  input  wire logic [NPORT-1:0] want_sd,
  input  wire logic [NPORT-1:0] want_cu,
  // Presence levels toward the block
  output logic      [NPORT-1:0] serdes_sig_det,
  output logic      [NPORT-1:0] cu_link_up
);
  // A module plugged in shows up one clock later, never in the same cycle.
  always @(posedge clk_sys) begin
    serdes_sig_det <= want_sd;
    cu_link_up     <= want_cu;
  end
endmodule

// ==== verif/pomc_top_monitor.sv ====
// Top-level checker for the operating mode register bank, bound to pomc_top.
`timescale 1ns/1ps
`include "pomc_defs.vh"

module pomc_checker #(
  parameter NPORT = 4
) (
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [1:0]         mac_if_mode,
  input wire logic               mac_serdes_sgmii_x,
  input wire logic               mac_serdes_qsgmii,
  input wire logic [NPORT-1:0]   media_x_mask,
  input wire logic [NPORT-1:0]   port_mac_1000x,
  input wire logic [3*NPORT-1:0] port_media_mode,
  input wire logic [NPORT-1:0]   port_auto_media_sensing,
  input wire logic [NPORT-1:0]   port_aneg_en,
  input wire logic [NPORT-1:0]   port_speed_1000_only,
  input wire logic [2*NPORT-1:0] port_mac_lane
);
  logic [31:0] wd1;
  logic [31:0] wd2;
  wire         wr_go = psel & penable & pready & pwrite;
  wire         act   = wr_go & (paddr == `POMC_A_CTRL) & pwdata[`POMC_CTL_RST];

  // Write data is delayed so results can be compared two edges after the write.
  always @(posedge clk_sys) begin
    wd1 <= pwdata;
    wd2 <= wd1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  bad_addr_a: assert property (psel && !penable && paddr[31:12] != 0 |=> pslverr)
    else $error("out of range address not refused");
  mac_if_a: assert property (wr_go && paddr == `POMC_A_GIF
    |-> ##2 mac_if_mode == wd2[15:14])
    else $error("MAC interface mode not taken from write");
  cmd_mac_a: assert property (wr_go && paddr == `POMC_A_CMD
    && pwdata[15:0] == `POMC_CMD_MAC |-> ##2 mac_serdes_sgmii_x && !mac_serdes_qsgmii)
    else $error("MAC SerDes command not applied");
  x_mask_a: assert property (wr_go && paddr == `POMC_A_CMD && pwdata[15]
    && pwdata[7:0] == `POMC_CMD_X |-> ##2 media_x_mask == wd2[11:8])
    else $error("media port mask wrong");
  fx_aneg_a: assert property ((port_media_mode[2:0] == `POMC_MED_FX
    && !port_auto_media_sensing[0])[*2] |-> !port_aneg_en[0])
    else $error("autonegotiation on for standalone FX");
  gig_only_a: assert property ((port_mac_1000x[0])[*2] |-> port_speed_1000_only[0])
    else $error("lower speeds offered to 1000BASE-X MAC");
  qsg_lane_a: assert property ((mac_if_mode == `POMC_GIF_QSG)[*2] |-> port_mac_lane == 0)
    else $error("QSGMII port not on lane zero");
  mode_hold_a: assert property (!act ##1 !act |=> $stable(port_media_mode)
    && $stable(port_mac_1000x))
    else $error("mode changed without software reset");
endmodule

bind pomc_top pomc_checker #(.NPORT(NPORT)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .mac_if_mode(mac_if_mode), .mac_serdes_sgmii_x(mac_serdes_sgmii_x),
  .mac_serdes_qsgmii(mac_serdes_qsgmii), .media_x_mask(media_x_mask),
  .port_mac_1000x(port_mac_1000x), .port_media_mode(port_media_mode),
  .port_auto_media_sensing(port_auto_media_sensing), .port_aneg_en(port_aneg_en),
  .port_speed_1000_only(port_speed_1000_only), .port_mac_lane(port_mac_lane));

// ==== verif/test_phy_operating_mode_config.sv ====
// Self-checking bench for the operating mode register bank.
`timescale 1ns/1ps
`include "pomc_defs.vh"
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module test_phy_operating_mode_config;
  typedef struct {logic [11:0] wa; logic [15:0] wd; logic [11:0] ra; logic [15:0] exp;} pomc_row_t;
  logic        clk_sys = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0000_0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  want_sd = 4'h0;
  logic [3:0]  want_cu = 4'h0;
  logic [31:0] rdv;
  logic        errv;
  wire  [31:0] prdata;
  wire         pready, pslverr, mac_sx, mac_q;
  wire  [3:0]  sig_det, cu_link, xm, fxm, m1000x, auto_media_sensing, aneg, cl37, spd;
  wire  [1:0]  mac_if_mode;
  wire  [11:0] mmode;
  wire  [7:0]  msel, lane;
  int          fails       = 0;
  int          checks_done = 0;
  // Command status packs x mask, fx mask and the two MAC SerDes bits.
  pomc_row_t   rows [7] = '{
    '{`POMC_A_GIF, 16'h0000, `POMC_A_GIF, 16'h0000},
    '{`POMC_A_CMD, 16'h80F0, `POMC_A_CSTAT, 16'h0100},
    '{`POMC_A_CMD, 16'h80E0, `POMC_A_CSTAT, 16'h0200},
    '{`POMC_A_CMD, 16'h83C1, `POMC_A_CSTAT, 16'h0203},
    '{`POMC_A_CMD, 16'h8CD1, `POMC_A_CSTAT, 16'h02C3},
    '{`POMC_A_CMD, 16'h81D1, `POMC_A_CSTAT, 16'h0212},
    '{`POMC_A_MACX, 16'h0080, `POMC_A_MACX, 16'h0080}};

  always #2.5 clk_sys = ~clk_sys;

  pomc_media_model #(.NPORT(4)) media (.clk_sys(clk_sys), .want_sd(want_sd),
    .want_cu(want_cu), .serdes_sig_det(sig_det), .cu_link_up(cu_link));

  pomc_top #(.NPORT(4)) dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serdes_sig_det(sig_det),
    .cu_link_up(cu_link), .mac_if_mode(mac_if_mode), .mac_serdes_sgmii_x(mac_sx),
    .mac_serdes_qsgmii(mac_q), .media_x_mask(xm), .media_fx_mask(fxm),
    .port_mac_1000x(m1000x), .port_media_mode(mmode), .port_auto_media_sensing(auto_media_sensing),
    .port_aneg_en(aneg), .port_cl37_en(cl37), .port_speed_1000_only(spd),
    .port_media_sel(msel), .port_mac_lane(lane));

  task automatic final_report();
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One idle cycle precedes every setup so psel is never assigned twice at one edge.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      final_report();
    end
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic activate(input logic [15:0] m);
    apb(1'b1, `POMC_A_MODE, {16'h0000, m});
    apb(1'b1, `POMC_A_CTRL, 32'h0000_9000);
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    apb(1'b0, `POMC_A_CTRL, 32'h0000_0000);
    `CHK(rdv[15:0], `POMC_CTL_RSTV)
    `CHK(aneg, 4'hF)
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, {20'h0_0000, rows[i].wa}, {16'h0000, rows[i].wd});
      apb(1'b0, {20'h0_0000, rows[i].ra}, 32'h0000_0000);
      `CHK(rdv[15:0], rows[i].exp)
    end
    `CHK({mac_sx, mac_q, xm, fxm}, 10'h121)
    `CHK(cl37, 4'h1)
    apb(1'b1, `POMC_A_BCAST, 32'h0000_0001);
    apb(1'b1, `POMC_A_MODE, 32'h0000_1200);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, `POMC_A_MODE, 32'h0000_0000);
    `CHK(rdv[15:0], 16'h0000)
    `CHK(m1000x[0], 1'b0)
    apb(1'b1, `POMC_A_CTRL, 32'h0000_9000);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, `POMC_A_MODE, 32'h0000_0000);
    `CHK(rdv[15:0], 16'h1200)
    `CHK({m1000x[0], spd[0], mmode[2:0]}, 5'b11_010)
    apb(1'b0, `POMC_A_CTRL, 32'h0000_0000);
    `CHK(rdv[15:0], 16'h1000)
    activate(16'h0300);
    `CHK({aneg[0], mmode[2:0]}, 4'b0_011)
    want_sd <= 4'h1;
    want_cu <= 4'h1;
    activate(16'h0E00);
    apb(1'b0, `POMC_A_EXTST, 32'h0000_0000);
    `CHK({auto_media_sensing[0], rdv[7:6], msel[1:0]}, 5'b1_10_10)
    activate(16'h0600);
    apb(1'b0, `POMC_A_EXTST, 32'h0000_0000);
    `CHK({rdv[7:6], msel[1:0]}, 4'b01_01)
    apb(1'b1, `POMC_A_GIF, 32'h0000_4000);
    repeat (3) @(posedge clk_sys);
    `CHK({mac_if_mode, lane}, 10'h100)
    apb(1'b1, `POMC_A_GIF, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    `CHK({mac_if_mode, lane}, 10'h0E4)
    apb(1'b1, `POMC_A_BCAST, 32'h0000_0001);
    activate(16'h0100);
    `CHK({m1000x, mmode}, 16'h0249)
    apb(1'b1, `POMC_A_BCAST, 32'h0000_0000);
    apb(1'b0, 32'h0000_0030, 32'h0000_0000);
    `CHK({errv, rdv}, 33'h1_0000_0000)
    apb(1'b1, 32'h0000_1000, 32'h0000_FFFF);
    `CHK(errv, 1'b1)
    apb(1'b0, `POMC_A_GIF, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0000)
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    apb(1'b0, `POMC_A_MODE, 32'h0000_0000);
    `CHK({rdv[15:0], mmode}, 28'h000_0000)
    final_report();
  end
endmodule
